// >>> pmd_pkg.sv
// Package of constants for the PCI bus-master DMA controller.
// What this block does
// - Win bus arbitration before any transaction.
// - Assert frame with address and command.
// - Target side paces data phases after address.
// - Deassert frame when word count runs out.
// - One transfer moves up to 4 kB.
// - Intack 0000, I/O read 0010, write 0011.
// - Memory 0110/0111, configuration 1010/1011.
// - Whole transfer attempted as one burst.
// - Retry or disconnect resumes from last good word.
// - No device select or target abort terminates.
// - Error field: none, master, parity, target abort.
// - Three 32-bit registers clear on reset.
// - Start address low two bits read zero.
// - Address registers advance when autoincrement option set.
// - RAM address bits above backend width read zero.
// - Done bit set at end, written 0 clears.
// - Direction bit: 1 PCI to RAM, 0 RAM to PCI.
// - Request bit stays set until completion, abort or a write of 0 while idle.
// - No transfer unless enable bit set.
// - Length field counts words down; zero means 1024 words.
// - Cycle type: memory, configuration, intack, I/O.
// - Completion sets status; write 1 clears; enable gates.
package pmd_pkg;
	localparam logic [7:0] OFF_PCI_ADDR = 8'h00;
	localparam logic [7:0] OFF_RAM_ADDR = 8'h04;
	localparam logic [7:0] OFF_CONTROL = 8'h08;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [31:0] DWORD_MASK = 32'hFFFF_FFFC;
	localparam int CTL_ERR_LSB = 0;
	localparam int CTL_DONE = 2;
	localparam int CTL_DIR = 3;
	localparam int CTL_REQ = 4;
	localparam int CTL_EN = 5;
	localparam int CTL_IST = 6;
	localparam int CTL_IEN = 7;
	localparam int CTL_CYC_LSB = 11;
	localparam int CTL_LEN_LSB = 18;
	localparam logic [1:0] ERR_NONE = 2'h0;
	localparam logic [1:0] ERR_MASTER = 2'h1;
	localparam logic [1:0] ERR_PARITY = 2'h2;
	localparam logic [1:0] ERR_TARGET = 2'h3;
	localparam logic [2:0] CYC_MEMORY = 3'h0;
	localparam logic [2:0] CYC_CONFIG = 3'h1;
	localparam logic [2:0] CYC_INTACK = 3'h2;
	localparam logic [2:0] CYC_IO = 3'h4;
	localparam logic [3:0] CMD_INTACK = 4'h0;
	localparam logic [3:0] CMD_IO_RD = 4'h2;
	localparam logic [3:0] CMD_IO_WR = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'hA;
	localparam logic [3:0] CMD_CFG_WR = 4'hB;
	localparam logic [3:0] BYTE_EN_ALL = 4'h0;
	localparam logic [10:0] MAX_WORDS = 11'h400;
	localparam logic [2:0] MABORT_CLKS = 3'h5;
	localparam int BACKEND_AW_DEFAULT = 24;
	typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_ADDR, ST_DATA, ST_TURN} pmd_state_type;
endpackage

// >>> pmd_dma.sv
// PCI bus-master DMA controller with AHB-Lite register access.
`timescale 1ns/1ns
`default_nettype none
module pmd_dma
	import pmd_pkg::*;
#(
	parameter int backend_address_width = BACKEND_AW_DEFAULT,
	parameter bit address_autoincrement_option = 1'b1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// AHB-Lite register slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// PCI arbitration.
	output logic req_n,
	input wire logic gnt_n,
	// PCI frame and initiator ready, three signals each.
	input wire logic frame_n_i,
	output logic frame_n_o,
	output logic frame_oe,
	input wire logic irdy_n_i,
	output logic irdy_n_o,
	output logic irdy_oe,
	// PCI address/data and command/byte enables.
	input wire logic [31:0] ad_i,
	output logic [31:0] ad_o,
	output logic ad_oe,
	output logic [3:0] cbe_o,
	output logic cbe_oe,
	// PCI target responses.
	input wire logic devsel_n,
	input wire logic trdy_n,
	input wire logic stop_n,
	input wire logic perr_n,
	// Local RAM backend.
	output logic [backend_address_width-1:0] be_addr,
	output logic [31:0] be_wdata,
	output logic be_we,
	input wire logic [31:0] be_rdata,
	// DMA completion interrupt.
	output logic dma_irq
);

	generate
		if (backend_address_width < 3 || backend_address_width > 32) begin : g_bad_width
			$error("backend_address_width must lie between 3 and 32");
		end
	endgenerate

	localparam logic [63:0] RA_SPAN = (64'h1 << backend_address_width) - 64'h1;
	localparam logic [31:0] RA_MASK = RA_SPAN[31:0] & DWORD_MASK;

	// Register bus state.
	logic wr_pend_q;
	logic rd_pend_q;
	logic [7:0] adr_q;
	logic hreadyout_q;
	logic [31:0] hrdata_q;
	// Software registers.
	logic [31:0] pa_q;
	logic [31:0] ra_q;
	logic [1:0] err_q;
	logic done_q;
	logic dir_q;
	logic req_q;
	logic en_q;
	logic ist_q;
	logic ien_q;
	logic [2:0] cyc_q;
	logic [9:0] len_q;
	logic irq_q;
	// Bus engine state.
	pmd_state_type st_q;
	logic [29:0] pci_cur_q;
	logic [29:0] ram_cur_q;
	logic [10:0] wl_q;
	logic [3:0] cmd_q;
	logic dsel_seen_q;
	logic [2:0] dcnt_q;
	logic resume_q;
	// Pin registers.
	logic req_n_q;
	logic frame_n_q;
	logic frame_oe_q;
	logic irdy_n_q;
	logic irdy_oe_q;
	logic [31:0] ad_o_q;
	logic ad_oe_q;
	logic [3:0] cbe_o_q;
	logic cbe_oe_q;
	logic [backend_address_width-1:0] be_addr_q;
	logic [31:0] be_wdata_q;
	logic be_we_q;

	logic ap_take;
	logic wr_pa;
	logic wr_ra;
	logic wr_ct;
	logic [31:0] ctl_rd;
	logic [10:0] wl_init;
	logic in_data;
	logic xfer;
	logic finish_ok;
	logic stop_seen;
	logic tabort;
	logic mabort;
	logic ev_abort;
	logic ev_end;

	function automatic logic [3:0] cmd_of(input logic [2:0] cyc, input logic dir);
		logic [3:0] c;
		c = CMD_MEM_WR;
		unique case (cyc)
			CYC_CONFIG: c = dir ? CMD_CFG_RD : CMD_CFG_WR;
			CYC_INTACK: c = CMD_INTACK;
			CYC_IO: c = dir ? CMD_IO_RD : CMD_IO_WR;
			default: c = dir ? CMD_MEM_RD : CMD_MEM_WR;
		endcase
		return c;
	endfunction

	function automatic logic [backend_address_width-1:0] be_of(input logic [29:0] w);
		logic [31:0] b;
		b = {w, 2'b00};
		return b[backend_address_width-1:0];
	endfunction

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = 1'b0;
	assign req_n = req_n_q;
	assign frame_n_o = frame_n_q;
	assign frame_oe = frame_oe_q;
	assign irdy_n_o = irdy_n_q;
	assign irdy_oe = irdy_oe_q;
	assign ad_o = ad_o_q;
	assign ad_oe = ad_oe_q;
	assign cbe_o = cbe_o_q;
	assign cbe_oe = cbe_oe_q;
	assign be_addr = be_addr_q;
	assign be_wdata = be_wdata_q;
	assign be_we = be_we_q;
	assign dma_irq = irq_q;

	assign ap_take = hsel && htrans[1] && hready;
	assign wr_pa = wr_pend_q && adr_q == OFF_PCI_ADDR;
	assign wr_ra = wr_pend_q && adr_q == OFF_RAM_ADDR;
	assign wr_ct = wr_pend_q && adr_q == OFF_CONTROL;

	always_comb begin
		ctl_rd = REG_RESET;
		ctl_rd[CTL_ERR_LSB +: 2] = err_q;
		ctl_rd[CTL_DONE] = done_q;
		ctl_rd[CTL_DIR] = dir_q;
		ctl_rd[CTL_REQ] = req_q;
		ctl_rd[CTL_EN] = en_q;
		ctl_rd[CTL_IST] = ist_q;
		ctl_rd[CTL_IEN] = ien_q;
		ctl_rd[CTL_CYC_LSB +: 3] = cyc_q;
		ctl_rd[CTL_LEN_LSB +: 10] = len_q;
	end

	// Reads take one wait state so that a write just before is always seen.
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			adr_q <= 8'h00;
			hreadyout_q <= 1'b1;
			hrdata_q <= REG_RESET;
		end else begin
			wr_pend_q <= ap_take && hwrite;
			rd_pend_q <= ap_take && !hwrite;
			hreadyout_q <= !(ap_take && !hwrite);
			if (ap_take) begin
				adr_q <= haddr[7:0];
			end
			if (rd_pend_q) begin
				unique case (adr_q)
					OFF_PCI_ADDR: hrdata_q <= pa_q;
					OFF_RAM_ADDR: hrdata_q <= ra_q;
					OFF_CONTROL: hrdata_q <= ctl_rd;
					default: hrdata_q <= REG_RESET;
				endcase
			end
		end
	end

	assign wl_init = (len_q == 10'h000) ? MAX_WORDS : {1'b0, len_q};
	assign in_data = st_q == ST_DATA;
	assign xfer = in_data && !trdy_n;
	assign finish_ok = xfer && wl_q == 11'h001;
	assign stop_seen = in_data && !stop_n;
	assign tabort = stop_seen && devsel_n && dsel_seen_q;
	assign mabort = in_data && !dsel_seen_q && devsel_n && dcnt_q == MABORT_CLKS - 3'h1;
	assign ev_abort = tabort || mabort;
	assign ev_end = finish_ok || stop_seen || mabort;

	// Start address registers: DWORD aligned, optionally tracking the transfer.
	always_ff @(posedge clk) begin
		if (rst) begin
			pa_q <= REG_RESET;
			ra_q <= REG_RESET;
		end else begin
			if (wr_pa) begin
				pa_q <= hwdata & DWORD_MASK;
			end
			if (wr_ra) begin
				ra_q <= hwdata & RA_MASK;
			end
			if (address_autoincrement_option && xfer) begin
				pa_q <= {pci_cur_q + 30'h1, 2'b00};
				ra_q <= {ram_cur_q + 30'h1, 2'b00} & RA_MASK;
			end
		end
	end

	// Control register; hardware events win over a software write in the same cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			err_q <= ERR_NONE;
			done_q <= 1'b0;
			dir_q <= 1'b0;
			req_q <= 1'b0;
			en_q <= 1'b0;
			ist_q <= 1'b0;
			ien_q <= 1'b0;
			cyc_q <= CYC_MEMORY;
			len_q <= 10'h000;
		end else begin
			if (wr_ct) begin
				err_q <= hwdata[CTL_ERR_LSB +: 2];
				done_q <= done_q && hwdata[CTL_DONE];
				dir_q <= hwdata[CTL_DIR];
				if (hwdata[CTL_REQ]) begin
					req_q <= 1'b1;
				end else if (st_q == ST_IDLE) begin
					req_q <= 1'b0;
				end
				en_q <= hwdata[CTL_EN];
				if (hwdata[CTL_IST]) begin
					ist_q <= 1'b0;
				end
				ien_q <= hwdata[CTL_IEN];
				cyc_q <= hwdata[CTL_CYC_LSB +: 3];
				len_q <= hwdata[CTL_LEN_LSB +: 10];
			end
			if (xfer) begin
				len_q <= len_q - 10'h001;
			end
			if (in_data && !perr_n) begin
				err_q <= ERR_PARITY;
			end
			if (mabort) begin
				err_q <= ERR_MASTER;
			end
			if (tabort) begin
				err_q <= ERR_TARGET;
			end
			if (finish_ok || ev_abort) begin
				done_q <= 1'b1;
				ist_q <= 1'b1;
				req_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= ist_q && ien_q;
		end
	end

	// Bus engine: arbitration, address phase, data phases and turnaround.
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= ST_IDLE;
			pci_cur_q <= 30'h0;
			ram_cur_q <= 30'h0;
			wl_q <= 11'h000;
			cmd_q <= CMD_MEM_WR;
			dsel_seen_q <= 1'b0;
			dcnt_q <= 3'h0;
			resume_q <= 1'b0;
			req_n_q <= 1'b1;
			frame_n_q <= 1'b1;
			frame_oe_q <= 1'b0;
			irdy_n_q <= 1'b1;
			irdy_oe_q <= 1'b0;
			ad_o_q <= 32'h0000_0000;
			ad_oe_q <= 1'b0;
			cbe_o_q <= BYTE_EN_ALL;
			cbe_oe_q <= 1'b0;
			be_addr_q <= '0;
			be_wdata_q <= 32'h0000_0000;
			be_we_q <= 1'b0;
		end else begin
			be_we_q <= 1'b0;
			unique case (st_q)
				ST_IDLE: begin
					frame_oe_q <= 1'b0;
					irdy_oe_q <= 1'b0;
					if (req_q && en_q) begin
						pci_cur_q <= pa_q[31:2];
						ram_cur_q <= ra_q[31:2];
						wl_q <= wl_init;
						cmd_q <= cmd_of(cyc_q, dir_q);
						be_addr_q <= be_of(ra_q[31:2]);
						req_n_q <= 1'b0;
						st_q <= ST_REQ;
					end
				end
				ST_REQ: begin
					frame_oe_q <= 1'b0;
					irdy_oe_q <= 1'b0;
					req_n_q <= 1'b0;
					be_addr_q <= be_of(ram_cur_q);
					if (!gnt_n && frame_n_i && irdy_n_i) begin
						req_n_q <= 1'b1;
						frame_n_q <= 1'b0;
						frame_oe_q <= 1'b1;
						irdy_n_q <= 1'b1;
						irdy_oe_q <= 1'b1;
						ad_o_q <= {pci_cur_q, 2'b00};
						ad_oe_q <= 1'b1;
						cbe_o_q <= cmd_q;
						cbe_oe_q <= 1'b1;
						st_q <= ST_ADDR;
					end
				end
				ST_ADDR: begin
					frame_n_q <= wl_q == 11'h001;
					irdy_n_q <= 1'b0;
					cbe_o_q <= BYTE_EN_ALL;
					ad_oe_q <= cmd_q[0];
					ad_o_q <= be_rdata;
					be_addr_q <= be_of(ram_cur_q + 30'h1);
					dsel_seen_q <= 1'b0;
					dcnt_q <= 3'h0;
					st_q <= ST_DATA;
				end
				ST_DATA: begin
					if (!devsel_n) begin
						dsel_seen_q <= 1'b1;
					end else if (!dsel_seen_q) begin
						dcnt_q <= dcnt_q + 3'h1;
					end
					if (xfer) begin
						pci_cur_q <= pci_cur_q + 30'h1;
						ram_cur_q <= ram_cur_q + 30'h1;
						wl_q <= wl_q - 11'h001;
						if (cmd_q[0]) begin
							ad_o_q <= be_rdata;
							be_addr_q <= be_of(ram_cur_q + 30'h2);
						end else begin
							be_wdata_q <= ad_i;
							be_addr_q <= be_of(ram_cur_q);
							be_we_q <= 1'b1;
						end
						frame_n_q <= wl_q <= 11'h002;
					end
					if (ev_end) begin
						frame_n_q <= 1'b1;
						irdy_n_q <= 1'b1;
						ad_oe_q <= 1'b0;
						cbe_oe_q <= 1'b0;
						resume_q <= !finish_ok && !ev_abort;
						st_q <= ST_TURN;
					end
				end
				ST_TURN: begin
					frame_oe_q <= 1'b0;
					irdy_oe_q <= 1'b0;
					if (resume_q) begin
						req_n_q <= 1'b0;
						st_q <= ST_REQ;
					end else begin
						st_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	a_arb_before_frame: assert property (@(posedge clk) disable iff (rst)
		$rose(frame_oe_q) |-> $past(!gnt_n) && $past(st_q) == ST_REQ)
		else $error("frame driven without grant");

	a_addr_phase_drive: assert property (@(posedge clk) disable iff (rst)
		st_q == ST_ADDR |-> !frame_n_q && ad_oe_q && cbe_oe_q && cbe_o_q == cmd_q && ad_o_q == {pci_cur_q, 2'b00})
		else $error("address phase not driven");

	a_data_follows: assert property (@(posedge clk) disable iff (rst)
		st_q == ST_ADDR |=> st_q == ST_DATA && !irdy_n_q && cbe_o_q == BYTE_EN_ALL)
		else $error("no data phase after address");

	a_frame_last_word: assert property (@(posedge clk) disable iff (rst)
		in_data && wl_q == 11'h001 |-> frame_n_q)
		else $error("frame held on last word");

	a_io_cmd_codes: assert property (@(posedge clk) disable iff (rst)
		st_q == ST_REQ && cyc_q == CYC_IO && $past(st_q) == ST_IDLE |-> cmd_q == (dir_q ? CMD_IO_RD : CMD_IO_WR))
		else $error("wrong I/O command code");

	a_mem_cmd_codes: assert property (@(posedge clk) disable iff (rst)
		st_q == ST_REQ && cyc_q == CYC_MEMORY && $past(st_q) == ST_IDLE |-> cmd_q == (dir_q ? CMD_MEM_RD : CMD_MEM_WR))
		else $error("wrong memory command code");

	a_retry_resumes: assert property (@(posedge clk) disable iff (rst)
		stop_seen && !tabort && !finish_ok |=> ##1 st_q == ST_REQ && !req_n_q)
		else $error("retry did not rearbitrate");

	a_master_abort: assert property (@(posedge clk) disable iff (rst)
		mabort |=> err_q == ERR_MASTER && done_q && !req_q ##1 st_q == ST_IDLE && !frame_oe_q)
		else $error("master abort not handled");

	a_target_abort: assert property (@(posedge clk) disable iff (rst)
		tabort |=> err_q == ERR_TARGET && done_q && !req_q ##1 st_q == ST_IDLE && !frame_oe_q)
		else $error("target abort not handled");

	a_regs_cleared: assert property (@(posedge clk)
		$past(rst) && !rst |-> pa_q == REG_RESET && ra_q == REG_RESET && ctl_rd == REG_RESET)
		else $error("registers not clear after reset");

	a_addr_align: assert property (@(posedge clk) disable iff (rst)
		pa_q[1:0] == 2'b00 && ra_q[1:0] == 2'b00 && (ra_q & ~RA_MASK) == 32'h0000_0000)
		else $error("address register bits out of range");

	a_done_on_finish: assert property (@(posedge clk) disable iff (rst)
		finish_ok |=> done_q && ist_q && !req_q)
		else $error("done not set at completion");

	a_req_held: assert property (@(posedge clk) disable iff (rst)
		st_q != ST_IDLE && req_q && !finish_ok && !ev_abort |=> req_q)
		else $error("request dropped while busy");

	a_need_enable: assert property (@(posedge clk) disable iff (rst)
		st_q == ST_IDLE && !en_q |=> st_q == ST_IDLE)
		else $error("transfer started while disabled");

	a_irq_gate: assert property (@(posedge clk) disable iff (rst)
		dma_irq |-> $past(ist_q) && $past(ien_q))
		else $error("interrupt without enabled status");

endmodule // pmd_dma
`default_nettype wire

// >>> pmd_pci_target.sv
// Behavioural PCI arbiter and zero-wait memory target facing the DMA master.
`timescale 1ns/1ns
`default_nettype none
module pmd_pci_target (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Misbehaviour selects.
	input wire logic abort_mode,
	input wire logic retry_mode,
	input wire logic perr_mode,
	input wire logic tabort_mode,
	// Resolved bus levels.
	input wire logic req_n,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic [31:0] ad,
	input wire logic [3:0] cbe,
	// Responses.
	output logic gnt_n,
	output logic devsel_n,
	output logic trdy_n,
	output logic stop_n,
	output logic perr_n,
	output logic [31:0] t_ad,
	output logic t_oe,
	output logic [3:0] last_cmd,
	output logic [3:0] addr_phases
);
	logic [31:0] mem [0:15];
	logic act_q;
	logic retried_q;
	logic [3:0] idx_q;

	// The target drives read data only while it has claimed the cycle.
	assign t_oe = act_q && !last_cmd[0] && !devsel_n;
	assign perr_n = !(perr_mode && act_q && !irdy_n);

	always @(posedge clk) begin
		if (rst) begin
			gnt_n <= 1'b1;
			act_q <= 1'b0;
			devsel_n <= 1'b1;
			trdy_n <= 1'b1;
			stop_n <= 1'b1;
			retried_q <= 1'b0;
			addr_phases <= 4'h0;
			last_cmd <= 4'h0;
			t_ad <= 32'h0;
			idx_q <= 4'h0;
		end else begin
			gnt_n <= req_n;
			if (!act_q && !frame_n) begin
				act_q <= 1'b1;
				last_cmd <= cbe;
				addr_phases <= addr_phases + 4'h1;
				idx_q <= ad[5:2];
				t_ad <= mem[ad[5:2]];
				devsel_n <= abort_mode;
				trdy_n <= abort_mode;
			end else if (act_q) begin
				if (!irdy_n && !trdy_n) begin
					if (last_cmd[0]) begin
						mem[idx_q] <= ad;
					end
					idx_q <= idx_q + 4'h1;
					t_ad <= mem[idx_q + 4'h1];
					// One retry on the second data phase, after one good word.
					if (retry_mode && !retried_q) begin
						trdy_n <= 1'b1;
						stop_n <= 1'b0;
						retried_q <= 1'b1;
					end
					// Target abort after one good word: devsel dropped together with stop.
					if (tabort_mode) begin
						devsel_n <= 1'b1;
						trdy_n <= 1'b1;
						stop_n <= 1'b0;
					end
				end
				if (!irdy_n && !stop_n) begin
					stop_n <= 1'b1;
				end
				if (frame_n && irdy_n) begin
					act_q <= 1'b0;
					devsel_n <= 1'b1;
					trdy_n <= 1'b1;
					stop_n <= 1'b1;
				end
			end
		end
	end
endmodule // pmd_pci_target
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the PCI bus-master DMA controller.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import pmd_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic abort_mode = 1'b0;
	logic retry_mode = 1'b0;
	logic perr_mode = 1'b0;
	logic tabort_mode = 1'b0;
	logic [31:0] hrdata, ad_o, ad, be_wdata, be_rdata, t_ad, rd;
	logic [31:0] noise = 32'h0;
	logic hreadyout, hresp, req_n, gnt_n, frame_n_o, frame_oe, irdy_n_o, irdy_oe, ad_oe, cbe_oe;
	logic devsel_n, trdy_n, stop_n, perr_n, be_we, dma_irq, t_oe, frame_n, irdy_n;
	logic [3:0] cbe_o, last_cmd, addr_phases;
	logic [23:0] be_addr;
	logic [31:0] ram [0:15];
	logic [2:0] cyc_t [0:4] = '{CYC_CONFIG, CYC_CONFIG, CYC_IO, CYC_IO, CYC_INTACK};
	logic [3:0] cmd_t [0:4] = '{CMD_CFG_RD, CMD_CFG_WR, CMD_IO_RD, CMD_IO_WR, CMD_INTACK};
	int err_count = 0;
	int check_count = 0;
	int i, k, dummy;

	always #50 clk = ~clk;
	// Control lines have pull-ups; the floating data bus shows a moving pattern.
	assign frame_n = frame_oe ? frame_n_o : 1'b1;
	assign irdy_n = irdy_oe ? irdy_n_o : 1'b1;
	assign ad = ad_oe ? ad_o : (t_oe ? t_ad : noise);
	assign be_rdata = ram[be_addr[5:2]];
	always @(posedge clk) begin
		noise <= ~{noise[0], noise[31:1]};
		if (be_we) ram[be_addr[5:2]] <= be_wdata;
	end

	pmd_dma #(.backend_address_width(24), .address_autoincrement_option(1'b1)) pmd_dma_inst (
		.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp, .req_n, .gnt_n, .frame_n_i(frame_n), .frame_n_o, .frame_oe,
		.irdy_n_i(irdy_n), .irdy_n_o, .irdy_oe, .ad_i(ad), .ad_o, .ad_oe, .cbe_o, .cbe_oe,
		.devsel_n, .trdy_n, .stop_n, .perr_n, .be_addr, .be_wdata, .be_we, .be_rdata, .dma_irq);

	pmd_pci_target pmd_pci_target_inst (.clk, .rst, .abort_mode, .retry_mode, .perr_mode, .tabort_mode, .req_n,
		.frame_n, .irdy_n, .ad, .cbe(cbe_o), .gnt_n, .devsel_n, .trdy_n, .stop_n, .perr_n, .t_ad, .t_oe,
		.last_cmd, .addr_phases);

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task run_dma(input int words, input logic [2:0] cyc, input logic dir, input logic [7:0] pa,
			input logic [7:0] ra, input logic [1:0] err);
		logic [31:0] exp;
		logic full;
		full = (err != ERR_MASTER) && (err != ERR_TARGET);
		exp = 32'hE4 | 32'(err) | (32'(dir) << CTL_DIR) | (32'(cyc) << CTL_CYC_LSB);
		xfer(1'b1, OFF_PCI_ADDR, {24'h0, pa});
		xfer(1'b1, OFF_RAM_ADDR, {24'h0, ra});
		xfer(1'b1, OFF_CONTROL, 32'hB0 | exp[13:8] << 8 | exp[3] << 3 | 32'(words & 1023) << CTL_LEN_LSB);
		k = 0;
		do begin
			xfer(1'b0, OFF_CONTROL, 32'h0);
			k++;
		end while (rd[CTL_DONE] !== 1'b1 && k < 600);
		if (rd[CTL_DONE] !== 1'b1) err_count++;
		chk(rd & (full ? 32'hFFFF_FFFF : 32'hF003_FFFF), exp);
		chk({31'h0, dma_irq}, 32'h1);
		if (full) begin
			rd_chk(OFF_PCI_ADDR, {24'h0, pa} + 32'(4 * words));
			rd_chk(OFF_RAM_ADDR, {24'h0, ra} + 32'(4 * words));
		end
		xfer(1'b1, OFF_CONTROL, 32'h40);
		rd_chk(OFF_CONTROL, 32'h0);
		chk({31'h0, dma_irq}, 32'h0);
	endtask

	task finish_test;
		$display("mismatches %0d comparisons %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		finish_test;
	end

	initial begin
		dummy = $urandom(42475);
		for (i = 0; i < 16; i++) begin
			ram[i] = $urandom;
			pmd_pci_target_inst.mem[i] = $urandom;
		end
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd_chk(OFF_PCI_ADDR, REG_RESET);
		rd_chk(OFF_RAM_ADDR, REG_RESET);
		rd_chk(OFF_CONTROL, REG_RESET);
		xfer(1'b1, OFF_PCI_ADDR, 32'hFFFF_FFFF);
		rd_chk(OFF_PCI_ADDR, 32'hFFFF_FFFC);
		xfer(1'b1, OFF_RAM_ADDR, 32'hFFFF_FFFF);
		rd_chk(OFF_RAM_ADDR, 32'h00FF_FFFC);
		xfer(1'b1, 8'h0C, 32'h1234_5678);
		rd_chk(8'h0C, 32'h0);
		run_dma(3, CYC_MEMORY, 1'b0, 8'h20, 8'h10, ERR_NONE);
		for (i = 0; i < 3; i++) chk(pmd_pci_target_inst.mem[8 + i], ram[4 + i]);
		chk({28'h0, last_cmd}, {28'h0, CMD_MEM_WR});
		retry_mode <= 1'b1;
		run_dma(4, CYC_MEMORY, 1'b1, 8'h00, 8'h30, ERR_NONE);
		for (i = 0; i < 4; i++) chk(ram[12 + i], pmd_pci_target_inst.mem[i]);
		chk({28'h0, last_cmd}, {28'h0, CMD_MEM_RD});
		chk({28'h0, addr_phases}, 32'h3);
		retry_mode <= 1'b0;
		for (i = 0; i < 5; i++) begin
			run_dma(1, cyc_t[i], ~i[0], 8'h3C, 8'h3C, ERR_NONE);
			chk({28'h0, last_cmd}, {28'h0, cmd_t[i]});
		end
		xfer(1'b1, OFF_CONTROL, 32'h0004_0010);
		repeat (20) @(posedge clk);
		chk({31'h0, req_n}, 32'h1);
		chk({28'h0, addr_phases}, 32'h8);
		xfer(1'b1, OFF_CONTROL, 32'h0);
		run_dma(1024, CYC_MEMORY, 1'b0, 8'h00, 8'h00, ERR_NONE);
		abort_mode <= 1'b1;
		run_dma(2, CYC_MEMORY, 1'b0, 8'h00, 8'h00, ERR_MASTER);
		chk({30'h0, req_n, frame_oe}, 32'h2);
		abort_mode <= 1'b0;
		tabort_mode <= 1'b1;
		run_dma(2, CYC_MEMORY, 1'b0, 8'h00, 8'h00, ERR_TARGET);
		chk({30'h0, req_n, frame_oe}, 32'h2);
		tabort_mode <= 1'b0;
		perr_mode <= 1'b1;
		run_dma(1, CYC_MEMORY, 1'b0, 8'h10, 8'h00, ERR_PARITY);
		perr_mode <= 1'b0;
		finish_test;
	end
endmodule // testbench
`default_nettype wire
